// file: hw/flash_cmd_map.vh
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
`define OP_BLOCK_WIPE 8'hD8
`define OP_CHIP_WIPE_A 8'h60
`define OP_CHIP_WIPE_B 8'hC7
`define OP_DEEP_SLEEP 8'hB9
`define OP_WAKE_ID 8'hAB
`define OP_MAKER_ID 8'h90
`define OP_MAKER_ID_DUAL 8'h92
`define OP_MAKER_ID_QUAD 8'h94
`define ID_ADDR_MAKER_FIRST 24'h000000
`define ID_ADDR_PART_FIRST 24'h000001
`define CLK_MHZ 100
`define BLOCK_WIPE_TIME_US 1000
`define CHIP_WIPE_TIME_US 5000
`define SLEEP_ENTRY_DELAY_US 3
`define WAKE_DELAY_US 3
`define WAKE_IDENTIFY_DELAY_US 5
`define BLOCK_WIPE_CYCLES (`BLOCK_WIPE_TIME_US * `CLK_MHZ)
`define CHIP_WIPE_CYCLES (`CHIP_WIPE_TIME_US * `CLK_MHZ)
`define SLEEP_ENTRY_CYCLES (`SLEEP_ENTRY_DELAY_US * `CLK_MHZ)
`define WAKE_CYCLES (`WAKE_DELAY_US * `CLK_MHZ)
`define WAKE_IDENTIFY_CYCLES (`WAKE_IDENTIFY_DELAY_US * `CLK_MHZ)
`define BLOCK_ADDR_MSB 23
`define BLOCK_ADDR_LSB 16
`endif

// file: hw/flash_erase_sleep_id.v
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
// How it works
// - D8 plus three address bytes erases the 64KB block holding the address.
// - erase runs only if the write latch was already set.
// - block erase counts only if select rises right after the 32nd bit.
// - valid block erase starts timed cycle; busy high, write latch cleared.
// - block erase refused when its block is protected.
// - chip erase is 60 or C7 alone, select rising after bit 8.
// - valid chip erase starts timed cycle; busy high, latch cleared.
// - chip erase runs only with no protection selected.
// - deep sleep is B9 alone, select rising after bit 8.
// - deep sleep entered only after the entry delay elapses.
// - in deep sleep every command except AB is ignored.
// - deep sleep command during a busy cycle is rejected.
// - select rising alone never enters deep sleep.
// - after reset the device starts in standby, not asleep.
// - AB releases deep sleep and high-performance mode.
// - plain AB wake blocks commands for the wake delay.
// - AB plus three dummy bytes repeats the part id msb first from standby; from deep sleep it sends no id.
// - id read that wakes blocks commands for the longer delay.
// - AB ignored while busy.
// - 90 with address 0 sends maker id then part id.
// - address 1 sends part id first.
// - 92 sends the id over two lines, 94 over four.
module flash_erase_sleep_id #(
    parameter [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter [7:0] PART_ID = 8'h3C, // arbitrary value
    parameter BLOCK_WIPE_CYCLES = `BLOCK_WIPE_CYCLES,
    parameter CHIP_WIPE_CYCLES = `CHIP_WIPE_CYCLES,
    parameter SLEEP_ENTRY_CYCLES = `SLEEP_ENTRY_CYCLES,
    parameter WAKE_CYCLES = `WAKE_CYCLES,
    parameter WAKE_IDENTIFY_CYCLES = `WAKE_IDENTIFY_CYCLES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire cs_n,
    input wire sclk,
    input wire [3:0] io_in,
    output reg [3:0] io_out,
    output reg [3:0] io_oe,
    input wire write_unlock_cmd,
    input wire region_protect_bit4,
    input wire [3:0] region_protect_low,
    input wire hpm_set,
    output wire op_busy_flag,
    output wire write_latch_flag,
    output wire deep_sleep_flag,
    output wire hpm_flag,
    output wire cmd_blocked,
    output reg block_wipe_strobe,
    output reg chip_wipe_strobe,
    output reg [7:0] wipe_block_ff
);
    localparam ST_IDLE = 3'd0;
    localparam ST_BWIPE = 3'd1;
    localparam ST_CWIPE = 3'd2;
    localparam ST_SLEEP_GO = 3'd3;
    localparam ST_ASLEEP = 3'd4;
    localparam ST_WAKE = 3'd5;
    localparam [31:0] CNT_ONE = 32'h00000001;

    // three-stage sync; edges judged from stages two and three only
    reg [2:0] cs_sync_ff;
    reg [2:0] ck_sync_ff;
    reg [2:0] d0_sync_ff;
    wire cs_low = ~cs_sync_ff[1] & ~cs_sync_ff[2];
    wire cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
    wire cs_fall = ~cs_sync_ff[1] & cs_sync_ff[2];
    wire ck_rise = ck_sync_ff[1] & ~ck_sync_ff[2];
    wire ck_fall = ~ck_sync_ff[1] & ck_sync_ff[2];

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_ff <= 3'h7;
            ck_sync_ff <= 3'h0;
            d0_sync_ff <= 3'h0;
        end else if (clk_en) begin
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
            ck_sync_ff <= {ck_sync_ff[1:0], sclk};
            d0_sync_ff <= {d0_sync_ff[1:0], io_in[0]};
        end
    end

    reg [2:0] state_ff;
    reg [31:0] cnt_ff;
    reg wel_ff;
    reg hpm_ff;
    reg [5:0] bit_cnt_ff;
    reg [7:0] op_ff;
    reg [23:0] addr_ff;
    reg [7:0] shift_ff;
    reg [3:0] out_bits_ff;
    reg out_second_ff;
    reg [1:0] lanes_ff;
    reg sending_ff;
    wire busy = (state_ff == ST_BWIPE) || (state_ff == ST_CWIPE);
    wire asleep = (state_ff == ST_ASLEEP);
    assign op_busy_flag = busy;
    assign write_latch_flag = wel_ff;
    assign deep_sleep_flag = asleep;
    assign hpm_flag = hpm_ff;
    assign cmd_blocked = (state_ff == ST_WAKE) || (state_ff == ST_SLEEP_GO);

    // sampled bit: shift_ff holds the bits so far, d is the newest
    wire [7:0] op_now = {shift_ff[6:0], d0_sync_ff[2]};

    // protection decode: any nonzero low bits protect part of the array
    wire any_protect = (region_protect_low != 4'h0);
    // bit4 picks the bottom half, else the top half is protected
    wire blk_protected = any_protect &&
        (region_protect_bit4 ? (addr_ff[`BLOCK_ADDR_MSB] == 1'b0) : (addr_ff[`BLOCK_ADDR_MSB] == 1'b1));

    // opcode and address shift on rising sclk, msb first
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= 6'h00;
            op_ff <= 8'h00;
            addr_ff <= 24'h000000;
            shift_ff <= 8'h00;
        end else if (clk_en) begin
            if (!cs_low) begin
                bit_cnt_ff <= 6'h00;
            end else if (ck_rise && bit_cnt_ff != 6'h3F) begin
                shift_ff <= op_now;
                bit_cnt_ff <= bit_cnt_ff + 6'h01;
                if (bit_cnt_ff == 6'h07) begin
                    op_ff <= op_now;
                end else if (bit_cnt_ff < 6'h20) begin
                    addr_ff <= {addr_ff[22:0], d0_sync_ff[2]};
                end
            end
        end
    end

    // output side: which opcodes may answer at all
    wire is_id_op = (op_ff == `OP_MAKER_ID) || (op_ff == `OP_MAKER_ID_DUAL) || (op_ff == `OP_MAKER_ID_QUAD);
    wire talk_op = is_id_op || (op_ff == `OP_WAKE_ID);

    // byte order picked by the whole 24-bit address matching 000001
    wire [7:0] id_first = (addr_ff == `ID_ADDR_PART_FIRST) ? PART_ID : MAKER_ID;
    wire [7:0] id_second = (addr_ff == `ID_ADDR_PART_FIRST) ? MAKER_ID : PART_ID;
    reg [7:0] out_byte_ff;

    // no answer while erasing, asleep or inside a wake or sleep delay
    wire may_talk = !busy && !asleep && !cmd_blocked;

    // first byte and lane count of a fresh read
    wire [7:0] byte_new = (op_ff == `OP_WAKE_ID) ? PART_ID : id_first;
    wire [1:0] lanes_new = (op_ff == `OP_MAKER_ID_QUAD) ? 2'd2 : (op_ff == `OP_MAKER_ID_DUAL) ? 2'd1 : 2'd0;

    // a read starts on the fall right after the 32nd bit; erase frames
    // of the same length must not light up the output lines
    wire start_talk = ck_fall && (bit_cnt_ff == 6'h20) && !sending_ff && may_talk && talk_op;

    // the starting fall already drives the msb, so the host sees bit 7
    // on the very next rise rather than one beat late
    wire [7:0] cur_byte = sending_ff ? out_byte_ff : byte_new;
    wire [1:0] cur_lanes = sending_ff ? lanes_ff : lanes_new;
    wire [3:0] cur_bits = sending_ff ? out_bits_ff : 4'h0;
    wire cur_second = sending_ff ? out_second_ff : 1'b0;
    // bits moved per fall: one, two or four lanes
    wire [3:0] cur_step = (cur_lanes == 2'd2) ? 4'd4 : (cur_lanes == 2'd1) ? 4'd2 : 4'd1;
    wire [3:0] bits_after = cur_bits + cur_step;

    // shift-out engine; cs high drops every lane at once
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
            out_byte_ff <= 8'h00;
            out_bits_ff <= 4'h0;
            out_second_ff <= 1'b0;
            lanes_ff <= 2'd0;
            sending_ff <= 1'b0;
        end else if (clk_en) begin
            if (!cs_low) begin
                io_oe <= 4'h0;
                sending_ff <= 1'b0;
            end else if (start_talk || (ck_fall && sending_ff)) begin
                sending_ff <= 1'b1;
                lanes_ff <= cur_lanes;
                // emit msb-first lanes, then advance
                if (cur_lanes == 2'd2) begin
                    io_out <= cur_byte[7:4];
                    io_oe <= 4'hF;
                    out_byte_ff <= {cur_byte[3:0], 4'h0};
                end else if (cur_lanes == 2'd1) begin
                    io_out <= {2'b00, cur_byte[7:6]};
                    io_oe <= 4'h3;
                    out_byte_ff <= {cur_byte[5:0], 2'b00};
                end else begin
                    // single line data leaves on lane one
                    io_out <= {2'b00, cur_byte[7], 1'b0};
                    io_oe <= 4'h2;
                    out_byte_ff <= {cur_byte[6:0], 1'b0};
                end
                out_bits_ff <= bits_after;
                out_second_ff <= cur_second;
                if (bits_after == 4'd8) begin
                    out_bits_ff <= 4'h0;
                    out_second_ff <= ~cur_second;
                    // the wake-id read repeats its byte; id reads alternate
                    if (op_ff == `OP_WAKE_ID) begin
                        out_byte_ff <= PART_ID;
                    end else begin
                        out_byte_ff <= cur_second ? id_first : id_second;
                    end
                end
            end
        end
    end

    // decode at select rise; exact bit count qualifies erase and sleep, AB needs at least 8 bits
    wire len8 = (bit_cnt_ff == 6'h08);
    wire len32 = (bit_cnt_ff == 6'h20);
    wire woke_with_id = (op_ff == `OP_WAKE_ID) && (bit_cnt_ff >= 6'h20);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 32'h00000000;
            wel_ff <= 1'b0;
            hpm_ff <= 1'b0;
            block_wipe_strobe <= 1'b0;
            chip_wipe_strobe <= 1'b0;
            wipe_block_ff <= 8'h00;
        end else if (clk_en) begin
            block_wipe_strobe <= 1'b0;
            chip_wipe_strobe <= 1'b0;
            if (write_unlock_cmd && !busy && !asleep) begin
                wel_ff <= 1'b1;
            end
            if (hpm_set && !asleep && !busy) begin
                hpm_ff <= 1'b1;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (cs_rise) begin
                        if (op_ff == `OP_BLOCK_WIPE && len32 && wel_ff && !blk_protected) begin
                            state_ff <= ST_BWIPE;
                            cnt_ff <= BLOCK_WIPE_CYCLES;
                            block_wipe_strobe <= 1'b1;
                            wipe_block_ff <= addr_ff[`BLOCK_ADDR_MSB:`BLOCK_ADDR_LSB];
                        end else if ((op_ff == `OP_CHIP_WIPE_A || op_ff == `OP_CHIP_WIPE_B) && len8 && wel_ff &&
                                     !any_protect) begin
                            state_ff <= ST_CWIPE;
                            cnt_ff <= CHIP_WIPE_CYCLES;
                            chip_wipe_strobe <= 1'b1;
                        end else if (op_ff == `OP_DEEP_SLEEP && len8) begin
                            state_ff <= ST_SLEEP_GO;
                            cnt_ff <= SLEEP_ENTRY_CYCLES;
                            hpm_ff <= 1'b0;
                        end else if (op_ff == `OP_WAKE_ID && bit_cnt_ff >= 6'h08) begin
                            hpm_ff <= 1'b0;
                        end
                    end
                end
                ST_BWIPE, ST_CWIPE: begin
                    // latch clears halfway, well before the end
                    if (cnt_ff == (state_ff == ST_BWIPE ? BLOCK_WIPE_CYCLES / 2 : CHIP_WIPE_CYCLES / 2)) begin
                        wel_ff <= 1'b0;
                    end
                    if (cnt_ff == CNT_ONE) begin
                        state_ff <= ST_IDLE;
                        wel_ff <= 1'b0;
                    end
                    cnt_ff <= cnt_ff - CNT_ONE;
                end
                ST_SLEEP_GO: begin
                    cnt_ff <= cnt_ff - CNT_ONE;
                    if (cnt_ff == CNT_ONE) begin
                        state_ff <= ST_ASLEEP;
                    end
                end
                ST_ASLEEP: begin
                    // only the wake command is heard here
                    if (cs_rise && op_ff == `OP_WAKE_ID && bit_cnt_ff >= 6'h08) begin
                        state_ff <= ST_WAKE;
                        hpm_ff <= 1'b0;
                        cnt_ff <= woke_with_id ? WAKE_IDENTIFY_CYCLES : WAKE_CYCLES;
                    end
                end
                ST_WAKE: begin
                    // a new select restarts nothing: commands stay blocked
                    cnt_ff <= cnt_ff - CNT_ONE;
                    if (cnt_ff == CNT_ONE) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: sim/flash_erase_sleep_id_properties.sv
`timescale 1ns/1ps
module flash_erase_sleep_id_checker #(
    parameter BLOCK_WIPE_CYCLES = 400,
    parameter CHIP_WIPE_CYCLES = 600
) (
    input wire sys_clk,
    input wire rst_n,
    input wire cs_n,
    input wire [3:0] region_protect_low,
    input wire op_busy_flag,
    input wire write_latch_flag,
    input wire deep_sleep_flag,
    input wire cmd_blocked,
    input wire block_wipe_strobe,
    input wire chip_wipe_strobe
);
    // windows below assume the bench's shortened wipe times of 400 and 600
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_block_busy_run: assert property (block_wipe_strobe |=> op_busy_flag [*8]) else $error("busy short");
    a_block_busy_end: assert property (block_wipe_strobe |-> ##[380:420] $fell(op_busy_flag)) else $error("block time");
    a_chip_busy_end: assert property (chip_wipe_strobe |-> ##[580:620] $fell(op_busy_flag)) else $error("chip time");
    a_wipe_needs_latch: assert property (block_wipe_strobe || chip_wipe_strobe |-> write_latch_flag) else $error("no latch");
    a_chip_needs_open: assert property (chip_wipe_strobe |-> region_protect_low == 4'h0) else $error("protected");
    a_wipe_after_deselect: assert property (block_wipe_strobe || chip_wipe_strobe |-> cs_n && $past(cs_n, 2)) else $error("cs low");
    a_asleep_no_wipe: assert property (deep_sleep_flag |-> !(block_wipe_strobe || chip_wipe_strobe)) else $error("wipe asleep");
    a_busy_never_asleep: assert property (op_busy_flag |-> !deep_sleep_flag) else $error("asleep busy");
    a_sleep_after_delay: assert property ($rose(deep_sleep_flag) |-> $past(cmd_blocked)) else $error("no delay");
    a_latch_gone_at_end: assert property ($fell(op_busy_flag) |-> !write_latch_flag) else $error("latch left");
    cover property (block_wipe_strobe);
    cover property (chip_wipe_strobe);
    cover property ($fell(deep_sleep_flag));
endmodule
bind flash_erase_sleep_id flash_erase_sleep_id_checker #(.BLOCK_WIPE_CYCLES(BLOCK_WIPE_CYCLES),
    .CHIP_WIPE_CYCLES(CHIP_WIPE_CYCLES)) chk_inst (.sys_clk, .rst_n, .cs_n, .region_protect_low, .op_busy_flag,
    .write_latch_flag, .deep_sleep_flag, .cmd_blocked, .block_wipe_strobe, .chip_wipe_strobe);

// file: sim/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_in,
    input wire [3:0] io_out
);
    // idle: deselected, clock parked low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_in = 4'hF;
    end
    // one frame: n command bits msb first, then beats of lanes-wide read data
    task automatic xfer(input logic [31:0] cmd, input int n, input int beats, input int lanes, output logic [15:0] rd);
        rd = 16'h0000;
        cs_n = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            io_in[0] = cmd[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        io_in[0] = ~io_in[0]; // released line never shows the last bit
        for (int i = 0; i < beats; i++) begin
            #80 sclk = 1'b1;
            rd = lanes == 1 ? {rd[14:0], io_out[1]} : lanes == 2 ? {rd[13:0], io_out[1:0]} : {rd[11:0], io_out};
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        #200;
    endtask
endmodule

// file: sim/test_flash_erase_sleep_id.sv
`timescale 1ns/1ps
module test_flash_erase_sleep_id;
    localparam logic [7:0] MK = 8'hC3; // arbitrary value
    localparam logic [7:0] PT = 8'h96; // arbitrary value
    logic sys_clk, rst_n, clk_en, write_unlock_cmd, region_protect_bit4, hpm_set;
    logic [3:0] region_protect_low;
    logic [15:0] rd;
    wire cs_n, sclk, op_busy_flag, write_latch_flag, deep_sleep_flag, hpm_flag, cmd_blocked;
    wire block_wipe_strobe, chip_wipe_strobe;
    wire [3:0] io_in, io_out, io_oe;
    wire [7:0] wipe_block_ff;
    int mismatches, num_checks, n_blk, n_chip;
    flash_erase_sleep_id #(.MAKER_ID(MK), .PART_ID(PT), .BLOCK_WIPE_CYCLES(400), .CHIP_WIPE_CYCLES(600),
        .SLEEP_ENTRY_CYCLES(5), .WAKE_CYCLES(40), .WAKE_IDENTIFY_CYCLES(60)) flash_erase_sleep_id_inst (.sys_clk,
        .rst_n, .clk_en, .cs_n, .sclk, .io_in, .io_out, .io_oe, .write_unlock_cmd, .region_protect_bit4,
        .region_protect_low, .hpm_set, .op_busy_flag, .write_latch_flag, .deep_sleep_flag, .hpm_flag,
        .cmd_blocked, .block_wipe_strobe, .chip_wipe_strobe, .wipe_block_ff);
    host_spi_model host_spi_model_inst (.cs_n, .sclk, .io_in, .io_out);
    // strobes are single-cycle, so count them rather than poll
    always @(posedge sys_clk) begin
        n_blk <= n_blk + block_wipe_strobe;
        n_chip <= n_chip + chip_wipe_strobe;
    end
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait for both the wipe cycle and any wake or sleep delay
    task automatic wait_idle;
        int i;
        for (i = 0; i < 2000 && (op_busy_flag !== 1'b0 || cmd_blocked !== 1'b0); i++) @(negedge sys_clk);
        if (i == 2000) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic pulse_unlock;
        @(negedge sys_clk) write_unlock_cmd = 1'b1;
        @(negedge sys_clk) write_unlock_cmd = 1'b0;
    endtask
    task automatic send(input logic [31:0] cmd, input int n);
        host_spi_model_inst.xfer(cmd, n, 0, 1, rd);
    endtask
    task automatic t_reset;
        chk({deep_sleep_flag, op_busy_flag, write_latch_flag, cmd_blocked, io_oe}, 16'h0000);
        send(32'h0, 0);
        chk(deep_sleep_flag, 1'b0);
    endtask
    task automatic t_block;
        send(32'hD8123456, 32);
        chk(n_blk, 0);
        pulse_unlock();
        {region_protect_bit4, region_protect_low} = 5'h11;
        send(32'hD8123456, 32);
        chk(n_blk, 0);
        region_protect_low = 4'h0;
        send(32'hD87FFFFF >> 1, 31);
        chk(n_blk, 0);
        send(32'hD87FABCD, 32);
        chk({n_blk[7:0], wipe_block_ff, op_busy_flag}, {8'h01, 8'h7F, 1'b1});
        send(32'hB9, 8);
        send(32'hAB, 8);
        chk({op_busy_flag, cmd_blocked}, 2'b10);
        wait_idle();
        chk({deep_sleep_flag, write_latch_flag}, 2'b00);
    endtask
    task automatic t_chip;
        logic [7:0] ops[2] = '{8'h60, 8'hC7};
        foreach (ops[k]) begin
            pulse_unlock();
            region_protect_low = 4'h2;
            send(ops[k], 8);
            chk(n_chip, k);
            region_protect_low = 4'h0;
            send(ops[k], 8);
            chk({n_chip[7:0], op_busy_flag}, {8'(k + 1), 1'b1});
            wait_idle();
        end
    endtask
    task automatic t_sleep;
        send(32'h172, 9);
        wait_idle();
        chk(deep_sleep_flag, 1'b0);
        send(32'hB9, 8);
        wait_idle();
        chk(deep_sleep_flag, 1'b1);
        pulse_unlock();
        send(32'hD8000000, 32);
        chk({n_blk[7:0], write_latch_flag}, {8'h01, 1'b0});
        send(32'hAB, 8);
        chk(cmd_blocked, 1'b1);
        wait_idle();
        send(32'hB9, 8);
        wait_idle();
        send(32'hAB000000, 32);
        repeat (30) @(negedge sys_clk);
        chk({deep_sleep_flag, cmd_blocked}, 2'b01);
        wait_idle();
        @(negedge sys_clk) hpm_set = 1'b1;
        @(negedge sys_clk) hpm_set = 1'b0;
        chk({deep_sleep_flag, hpm_flag}, 2'b01);
        send(32'hAB, 8);
        wait_idle();
        chk(hpm_flag, 1'b0);
        // frozen clock enable must swallow the set pulse
        @(negedge sys_clk) clk_en = 1'b0;
        @(negedge sys_clk) hpm_set = 1'b1;
        @(negedge sys_clk) hpm_set = 1'b0;
        chk(hpm_flag, 1'b0);
        clk_en = 1'b1;
    endtask
    task automatic t_id;
        for (int m = 0; m < 6; m++) begin
            host_spi_model_inst.xfer({8'h90 + 8'(2 * (m / 2)), 24'(m % 2)}, 32, 16 >> (m / 2), 1 << (m / 2), rd);
            chk(rd, m % 2 ? {PT, MK} : {MK, PT});
        end
        host_spi_model_inst.xfer(32'hAB000000, 32, 16, 1, rd);
        chk({rd, io_oe}, {PT, PT, 4'h0});
    endtask
    initial begin
        {rst_n, write_unlock_cmd, region_protect_bit4, hpm_set, region_protect_low} = 8'h00;
        {mismatches, num_checks, n_blk, n_chip} = '0;
        clk_en = 1'b1;
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_block();
        t_chip();
        t_sleep();
        t_id();
        final_report();
    end
endmodule
